// ### common/acc_pkg.sv
// acc_pkg: constants, types and decode functions of the agp command register block
// assumes: one 40 MHz clock; used by the register bank and the operation gate
`default_nettype none
package acc_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ACC_CMD_ADDR = 8'hA8;
   localparam logic [31:0] ACC_CMD_RST_V2 = 32'h00000000;
   localparam logic [31:0] ACC_CMD_RST_V3 = 32'h00000A00;
   localparam logic [31:0] ACC_CMD_WMASK = 32'h00001F17;
   localparam int ACC_CAL_LSB = 10;
   localparam int ACC_CAL_MSB = 12;
   localparam int ACC_SBA_BIT = 9;
   localparam int ACC_EN_BIT = 8;
   localparam int ACC_FW_BIT = 4;
   localparam int ACC_RATE_MSB = 2;
   localparam logic [2:0] ACC_CAL_NONE = 3'h7;
   localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
   // ==========================================================
   // timing
   localparam int ACC_CLK_PERIOD_NS = 25;
   localparam int ACC_CAL_UNIT_MS = 4;
   localparam int ACC_CAL_UNIT_CYC = ACC_CAL_UNIT_MS * 1000000 / ACC_CLK_PERIOD_NS;
   localparam int ACC_SYNC_STAGES = 3;
   // ==========================================================
   // types and decoders
   typedef enum logic [3:0] {
      ACC_RATE_1X = 4'h1,
      ACC_RATE_4X = 4'h2,
      ACC_RATE_8X = 4'h4,
      ACC_RATE_BAD = 4'h8
   } acc_rate_t;

   function automatic acc_rate_t acc_rate_decode(input logic v3, input logic [2:0] sel);
      acc_rate_t r;
      r = ACC_RATE_BAD;
      case (sel)
         3'h1: r = v3 ? ACC_RATE_4X : ACC_RATE_1X;
         3'h2: r = v3 ? ACC_RATE_8X : ACC_RATE_BAD;
         3'h4: r = v3 ? ACC_RATE_BAD : ACC_RATE_4X;
         default: r = ACC_RATE_BAD;
      endcase
      return r;
   endfunction

   // number of 4 ms units per calibration period, zero for none
   function automatic logic [6:0] acc_cal_units(input logic [2:0] code);
      logic [6:0] u;
      u = 7'h00;
      case (code)
         3'h0: u = 7'h01;
         3'h1: u = 7'h04;
         3'h2: u = 7'h10;
         3'h3: u = 7'h40;
         default: u = 7'h00;
      endcase
      return u;
   endfunction
endpackage
`default_nettype wire

// ### common/acc_ctl_if.sv
// acc_ctl_if: enables passed from the command register to the operation gate
// assumes: both ends on aclk
`default_nettype none
interface acc_ctl_if;
   logic agp_enable;
   logic sideband_enable;
   logic rate_is_1x;
   modport ctl (output agp_enable, output sideband_enable, output rate_is_1x);
   modport gate (input agp_enable, input sideband_enable, input rate_is_1x);
endinterface
`default_nettype wire

// ### core/acc_op_gate.sv
// acc_op_gate: admits or ignores agp operations according to the command enables
// assumes: request inputs come from logic on aclk; op_done pulses once per finished operation
`default_nettype none
module acc_op_gate
   import acc_pkg::*;
#(
   parameter int INFLIGHT_W = 6
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   acc_ctl_if.gate ctl,
   input wire logic pipe_req,
   input wire logic sync_req,
   input wire logic sba_frag_valid,
   input wire logic sba_frag_last,
   input wire logic op_done,
   output logic pipe_accept,
   output logic sync_accept,
   output logic sba_frag_accept,
   output logic sba_issue,
   output logic servicing
);
   // ==========================================================
   // admission and in-flight tracking
   logic sba_partial_q;
   logic sba_partial_d;
   logic [INFLIGHT_W-1:0] inflight_q;
   logic [INFLIGHT_W-1:0] inflight_d;
   logic sba_open;
   logic [1:0] inc;
   logic dec;

   always_comb
   begin
      sba_open = ctl.agp_enable & ctl.sideband_enable;
      pipe_accept = clk_en & pipe_req & ctl.agp_enable;
      sync_accept = clk_en & sync_req & ctl.agp_enable;
      // a 1x command already under way finishes even if the enable drops
      sba_frag_accept = clk_en & sba_frag_valid & (sba_open | sba_partial_q);
      sba_issue = sba_frag_accept & sba_frag_last;
      sba_partial_d = sba_partial_q;
      if (sba_frag_accept)
      begin
         sba_partial_d = ~sba_frag_last & ctl.rate_is_1x;
      end
      inc = {1'b0, pipe_accept} + {1'b0, sba_issue};
      dec = op_done & (|inflight_q);
      // no saturation: the far end never has more than 2**INFLIGHT_W-1 open
      inflight_d = inflight_q + INFLIGHT_W'(inc) - INFLIGHT_W'(dec);
      servicing = ctl.agp_enable | (|inflight_q);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sba_partial_q <= 1'b0;
         inflight_q <= '0;
      end
      else if (clk_en)
      begin
         sba_partial_q <= sba_partial_d;
         inflight_q <= inflight_d;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   gate_closed_a: assert property ((!ctl.agp_enable && !sba_partial_q)
      |-> !(pipe_accept || sync_accept || sba_frag_accept))
      else $error("operation admitted while disabled");
   sba_finish_a: assert property ((clk_en && sba_frag_accept && !sba_frag_last && ctl.rate_is_1x)
      |=> sba_partial_q && (!clk_en || !sba_frag_valid || sba_frag_accept))
      else $error("partial 1x sideband command dropped");
   service_hold_a: assert property ((clk_en && pipe_accept && !op_done) |=> servicing)
      else $error("accepted operation not serviced");

   sba_late_c: cover property (sba_frag_accept && !ctl.agp_enable);
   pipe_ok_c: cover property (pipe_accept ##[1:40] op_done);
endmodule
`default_nettype wire

// ### core/acc_command_control.sv
// acc_command_control: agp command register on an axi4-lite slave, with mode latch,
// calibration timer and operation admission
// assumes: axi master on aclk; power_good and the reference comparator are asynchronous pins
//
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
module acc_command_control
   import acc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CAL_UNIT_CYCLES = ACC_CAL_UNIT_CYC,
   parameter int INFLIGHT_W = 6
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic power_good,
   input wire logic graphics_reference_voltage,
   input wire logic pipe_req,
   input wire logic sync_req,
   input wire logic sba_frag_valid,
   input wire logic sba_frag_last,
   input wire logic op_done,
   output logic pipe_accept,
   output logic sync_accept,
   output logic sba_frag_accept,
   output logic sba_issue,
   output logic servicing,
   output logic signalling_v3,
   output logic sideband_active,
   output logic fast_write_active,
   output logic [3:0] transfer_rate,
   output logic cal_request
);
   localparam int UW = $clog2(CAL_UNIT_CYCLES + 1);
   localparam int NPIN = 2;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      return {a[ADDR_W-1:2], 2'b00} == ADDR_W'(ACC_CMD_ADDR);
   endfunction

   // ==========================================================
   // pin synchronisers: a level counts once stages two and three agree
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_flt;
   assign pin_raw = {power_good, graphics_reference_voltage};

   genvar g;
   for (g = 0; g < NPIN; g++)
   begin : g_sync
      logic [ACC_SYNC_STAGES-1:0] st_q;
      logic [ACC_SYNC_STAGES-1:0] st_d;
      logic flt_q;
      logic flt_d;
      always_comb
      begin
         st_d = {st_q[ACC_SYNC_STAGES-2:0], pin_raw[g]};
         flt_d = (st_q[1] == st_q[2]) ? st_q[2] : flt_q;
      end
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            st_q <= '0;
            flt_q <= 1'b0;
         end
         else if (clk_en)
         begin
            st_q <= st_d;
            flt_q <= flt_d;
         end
      end
      assign pin_flt[g] = flt_q;
   end

   // ==========================================================
   // signalling mode: comparator is followed live until power good rises
   logic pg;
   logic vref_v3;
   logic mode_q;
   logic mode_d;
   logic pg_prev_q;
   logic pg_rise;

   always_comb
   begin
      pg = pin_flt[1];
      vref_v3 = pin_flt[0];
      mode_d = pg ? mode_q : vref_v3;
      pg_rise = pg & ~pg_prev_q;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_q <= 1'b0;
         pg_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         mode_q <= mode_d;
         pg_prev_q <= pg;
      end
   end

   // ==========================================================
   // axi4-lite write channel
   logic aw_have_q;
   logic aw_have_d;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [ADDR_W-1:0] aw_addr_d;
   logic w_have_q;
   logic w_have_d;
   logic [31:0] w_data_q;
   logic [31:0] w_data_d;
   logic [3:0] w_strb_q;
   logic [3:0] w_strb_d;
   logic bvalid_q;
   logic bvalid_d;
   logic [1:0] bresp_q;
   logic [1:0] bresp_d;
   logic aw_take;
   logic w_take;
   logic do_write;

   always_comb
   begin
      s_axi_awready = clk_en & ~aw_have_q & ~bvalid_q;
      s_axi_wready = clk_en & ~w_have_q & ~bvalid_q;
      aw_take = s_axi_awvalid & s_axi_awready;
      w_take = s_axi_wvalid & s_axi_wready;
      do_write = aw_have_q & w_have_q & ~bvalid_q;
      aw_have_d = aw_have_q | aw_take;
      w_have_d = w_have_q | w_take;
      aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
      w_data_d = w_take ? s_axi_wdata : w_data_q;
      w_strb_d = w_take ? s_axi_wstrb : w_strb_q;
      bvalid_d = bvalid_q & ~s_axi_bready;
      bresp_d = bresp_q;
      if (do_write)
      begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = addr_hit(aw_addr_q) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= ACC_RESP_OKAY;
      end
      else if (clk_en)
      begin
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q <= w_have_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ==========================================================
   // command register
   logic [12:0] cmd_q;
   logic [12:0] cmd_d;
   logic [12:0] wmask;
   logic [31:0] lane_mask;

   always_comb
   begin
      lane_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
      // reserved and read-only bits stay out of the mask, so they hold zero
      wmask = ACC_CMD_WMASK[12:0] & lane_mask[12:0];
      cmd_d = cmd_q;
      if (pg_rise)
      begin
         cmd_d = mode_q ? ACC_CMD_RST_V3[12:0] : ACC_CMD_RST_V2[12:0];
      end
      else if (do_write && addr_hit(aw_addr_q))
      begin
         // every calibration code is stored; software picks a legal one
         cmd_d = (cmd_q & ~wmask) | (w_data_q[12:0] & wmask);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmd_q <= ACC_CMD_RST_V2[12:0];
      end
      else if (clk_en)
      begin
         cmd_q <= cmd_d;
      end
   end

   // ==========================================================
   // axi4-lite read channel
   logic rvalid_q;
   logic rvalid_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   logic ar_take;

   always_comb
   begin
      s_axi_arready = clk_en & ~rvalid_q;
      ar_take = s_axi_arvalid & s_axi_arready;
      rvalid_d = rvalid_q & ~s_axi_rready;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (ar_take)
      begin
         rvalid_d = 1'b1;
         rdata_d = addr_hit(s_axi_araddr) ? {19'h00000, cmd_q} : 32'h00000000;
         rresp_d = addr_hit(s_axi_araddr) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= ACC_RESP_OKAY;
      end
      else if (clk_en)
      begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // ==========================================================
   // decoded port controls
   acc_rate_t rate;

   always_comb
   begin
      rate = acc_rate_decode(mode_q, cmd_q[ACC_RATE_MSB:0]);
      signalling_v3 = mode_q;
      sideband_active = mode_q | cmd_q[ACC_SBA_BIT];
      transfer_rate = rate;
      // an illegal rate pattern falls back to plain writes
      fast_write_active = cmd_q[ACC_FW_BIT] & (rate != ACC_RATE_1X) & (rate != ACC_RATE_BAD);
   end

   acc_ctl_if ctl_if();
   assign ctl_if.agp_enable = cmd_q[ACC_EN_BIT];
   assign ctl_if.sideband_enable = sideband_active;
   assign ctl_if.rate_is_1x = (rate == ACC_RATE_1X);

   acc_op_gate #(.INFLIGHT_W(INFLIGHT_W)) u_gate (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .ctl(ctl_if.gate),
      .pipe_req(pipe_req),
      .sync_req(sync_req),
      .sba_frag_valid(sba_frag_valid),
      .sba_frag_last(sba_frag_last),
      .op_done(op_done),
      .pipe_accept(pipe_accept),
      .sync_accept(sync_accept),
      .sba_frag_accept(sba_frag_accept),
      .sba_issue(sba_issue),
      .servicing(servicing)
   );

   // ==========================================================
   // calibration timer: counts 4 ms units, restarts whenever the period is off
   logic [UW-1:0] unit_q;
   logic [UW-1:0] unit_d;
   logic [6:0] mult_q;
   logic [6:0] mult_d;
   logic cal_q;
   logic cal_d;
   logic [6:0] units;

   always_comb
   begin
      units = acc_cal_units(cmd_q[ACC_CAL_MSB:ACC_CAL_LSB]);
      unit_d = unit_q + UW'(1);
      mult_d = mult_q;
      cal_d = 1'b0;
      if (units == 7'h00)
      begin
         unit_d = '0;
         mult_d = 7'h00;
      end
      else if (unit_q >= UW'(CAL_UNIT_CYCLES - 1))
      begin
         unit_d = '0;
         mult_d = 7'(mult_q + 7'h01);
         if (7'(mult_q + 7'h01) >= units)
         begin
            mult_d = 7'h00;
            cal_d = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         unit_q <= '0;
         mult_q <= 7'h00;
         cal_q <= 1'b0;
      end
      else if (clk_en)
      begin
         unit_q <= unit_d;
         mult_q <= mult_d;
         cal_q <= cal_d;
      end
   end

   assign cal_request = cal_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   rst_v3_a: assert property ((clk_en && pg_rise && mode_q) |=> cmd_q == ACC_CMD_RST_V3[12:0])
      else $error("3.0 default not loaded");
   rst_v2_a: assert property ((clk_en && pg_rise && !mode_q) |=> cmd_q == ACC_CMD_RST_V2[12:0])
      else $error("2.0 default not loaded");
   sba_auto_a: assert property (mode_q |-> sideband_active && ctl_if.sideband_enable)
      else $error("sideband off in 3.0 mode");
   rd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:13] == 19'h00000
      && s_axi_rdata[7:5] == 3'h0 && !s_axi_rdata[3])
      else $error("reserved or read-only bit reads one");
   fw_plain_a: assert property ((!cmd_q[ACC_FW_BIT] || transfer_rate == ACC_RATE_1X) |-> !fast_write_active)
      else $error("fast write with it disabled or at 1x");
   fw_on_a: assert property ((cmd_q[ACC_FW_BIT] && $onehot(cmd_q[2:0]) && !mode_q && cmd_q[2])
      |-> fast_write_active && transfer_rate == ACC_RATE_4X)
      else $error("fast write not used at 4x");
   bresp_time_a: assert property ((aw_take && w_take) ##1 clk_en |=> s_axi_bvalid)
      else $error("write response late");
   cal_none_a: assert property ((clk_en && cmd_q[ACC_CAL_MSB:ACC_CAL_LSB] == ACC_CAL_NONE) |=> !cal_request)
      else $error("calibration with none selected");
   mode_hold_a: assert property ((pg && $past(pg)) |-> $stable(mode_q))
      else $error("mode changed while power good");

   wr_cmd_c: cover property (do_write && addr_hit(aw_addr_q));
   cal_tick_c: cover property (cal_request);
   v3_mode_c: cover property (pg_rise && mode_q);
endmodule
`default_nettype wire

// ### verification/acc_agp_master.sv
// acc_agp_master: behavioural graphics master that issues requests and reports completions
// assumes: the bench calls send; shares aclk with the command block
`default_nettype none
module acc_agp_master
(
   input wire logic aclk,
   input wire logic pipe_accept,
   input wire logic sync_accept,
   input wire logic sba_frag_accept,
   input wire logic sba_issue,
   output logic pipe_req = 1'b0,
   output logic sync_req = 1'b0,
   output logic sba_frag_valid = 1'b0,
   output logic sba_frag_last = 1'b0,
   output logic op_done = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   int done_delay = 2;
   int owed = 0;
   int age = 0;
   // ==========================================================
   // completions: one pulse per cycle with an accepted pipe or an issued sideband command, late when asked
   always @(posedge aclk)
   begin
      if ((pipe_req === 1'b1 && pipe_accept === 1'b1) || sba_issue === 1'b1)
         owed = owed + 1;
      if (owed > 0)
         age = age + 1;
      op_done <= (age > done_delay);
      if (age > done_delay)
      begin
         owed = owed - 1;
         age = 0;
      end
   end
   // ==========================================================
   // one request strobe; kind 0 pipe, 1 sync, 2 sideband fragment
   task automatic send(input int kind, input logic last, output logic acc, output logic iss);
      @(posedge aclk);
      pipe_req <= (kind == 0);
      sync_req <= (kind == 1);
      sba_frag_valid <= (kind == 2);
      sba_frag_last <= last;
      @(posedge aclk);
      acc = (kind == 0) ? pipe_accept : (kind == 1) ? sync_accept : sba_frag_accept;
      iss = sba_issue;
      pipe_req <= 1'b0;
      sync_req <= 1'b0;
      sba_frag_valid <= 1'b0;
      // no pull on this line: show the inverse once unqualified
      sba_frag_last <= ~last;
   endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// testbench: drives the command block over axi4-lite and the agp request ports
// assumes: acc_pkg compiled first; calibration unit shortened to 8 cycles
`default_nettype none
module testbench
   import acc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CAL_U = 8;
   logic aclk = 1'b0, aresetn = 1'b0, pg = 1'b0, ref_v3 = 1'b0, ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdata, r;
   logic [3:0] wstrb = 4'h0, rate;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, a, s;
   logic [1:0] bresp, rresp;
   logic preq, sreq, fv, fl, done, pacc, sacc, facc, issue, servicing, v3, sb_act, fw_act, cal_req;
   int bad_count = 0;
   int checks_done = 0;
   logic [33:0] rd_q[$];
   logic [1:0] wr_q[$];
   always #12.5 aclk = ~aclk;
   acc_command_control #(.CAL_UNIT_CYCLES(CAL_U)) u_acc_command_control (.aclk(aclk), .aresetn(aresetn),
      .clk_en(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_good(pg), .graphics_reference_voltage(ref_v3),
      .pipe_req(preq), .sync_req(sreq), .sba_frag_valid(fv), .sba_frag_last(fl), .op_done(done),
      .pipe_accept(pacc), .sync_accept(sacc), .sba_frag_accept(facc), .sba_issue(issue),
      .servicing(servicing), .signalling_v3(v3), .sideband_active(sb_act), .fast_write_active(fw_act),
      .transfer_rate(rate), .cal_request(cal_req));
   acc_agp_master u_acc_agp_master (.aclk(aclk), .pipe_accept(pacc), .sync_accept(sacc),
      .sba_frag_accept(facc), .sba_issue(issue), .pipe_req(preq), .sync_req(sreq),
      .sba_frag_valid(fv), .sba_frag_last(fl), .op_done(done));
   // ==========================================================
   // comparison, verdict and hang guard
   task automatic check(input string n, input logic [33:0] seen, input logic [33:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic timeout(input string n);
      bad_count++;
      $display("ERROR %s wait ran out", n);
      final_report();
   endtask
   // ==========================================================
   // axi4-lite master: valid held until its ready, answer taken at the handshake edge
   task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] st, input logic [1:0] rsp);
      int n;
      wr_q.push_back(rsp);
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100 && bvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      if (n == 100)
         timeout("bvalid");
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] ad, input logic [33:0] exp);
      int n;
      rd_q.push_back(exp);
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100 && rvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      if (n == 100)
         timeout("rvalid");
      rready <= 1'b0;
   endtask
   // answers are matched against the oldest note of the driver
   always @(posedge aclk)
   begin
      if (rvalid === 1'b1 && rready === 1'b1)
         check("read", {rresp, rdata}, rd_q.size() ? rd_q.pop_front() : 34'h3FFFFFFFF);
      if (bvalid === 1'b1 && bready === 1'b1)
         check("bresp", bresp, wr_q.size() ? wr_q.pop_front() : 2'h3);
   end
   task automatic op(input int k, input logic l, input logic ea, input logic ei);
      u_acc_agp_master.send(k, l, a, s);
      check("accept", a, ea);
      check("issue", s, ei);
   endtask
   task automatic rate_check(input logic mode3);
      logic [2:0] c;
      logic fw;
      logic [3:0] er;
      for (int i = 0; i < 4; i++)
      begin
         c = 3'h1 << (i % 3);
         fw = (i < 3);
         er = !mode3 ? (c == 3'h1 ? 4'h1 : c == 3'h4 ? 4'h2 : 4'h8) : (c == 3'h1 ? 4'h2 : c == 3'h2 ? 4'h4 : 4'h8);
         axi_write(ACC_CMD_ADDR, {27'h0, fw, 1'b0, c}, 4'hF, ACC_RESP_OKAY);
         @(posedge aclk);
         check("rate", rate, er);
         check("fast write", fw_act, fw && er != 4'h1 && er != 4'h8);
      end
   endtask
   // gap between two calibration pulses, 0 if none, -1 if only one
   task automatic cal_check(input logic [2:0] c);
      int t0, t1;
      t0 = -1;
      t1 = -1;
      axi_write(ACC_CMD_ADDR, {19'h0, c, 10'h0}, 4'hF, ACC_RESP_OKAY);
      for (int n = 0; n < 1200; n++)
      begin
         @(posedge aclk);
         if (cal_req === 1'b1 && t0 < 0)
            t0 = n;
         else if (cal_req === 1'b1 && t1 < 0)
            t1 = n;
      end
      check("cal gap", (t0 < 0) ? 0 : (t1 < 0) ? -1 : t1 - t0, (c < 4) ? CAL_U << (2 * c) : 0);
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      r = $urandom(32'h9b7d);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      pg <= 1'b1;
      repeat (10) @(posedge aclk);
      axi_read(ACC_CMD_ADDR, {ACC_RESP_OKAY, 32'h00000000});
      check("mode", v3, 1'b0);
      $display("test reset value done");
      for (int i = 0; i < 3; i++)
      begin
         r = $urandom;
         axi_write(ACC_CMD_ADDR, r, 4'hF, ACC_RESP_OKAY);
         axi_read(ACC_CMD_ADDR, {ACC_RESP_OKAY, r & ACC_CMD_WMASK});
      end
      axi_write(ACC_CMD_ADDR, 32'h00000000, 4'hF, ACC_RESP_OKAY);
      axi_write(ACC_CMD_ADDR, 32'hFFFFFFFF, 4'h2, ACC_RESP_OKAY);
      axi_read(ACC_CMD_ADDR, {ACC_RESP_OKAY, 32'h00001F00});
      axi_write(8'hAC, 32'hFFFFFFFF, 4'hF, ACC_RESP_SLVERR);
      axi_read(8'hAC, {ACC_RESP_SLVERR, 32'h00000000});
      axi_read(ACC_CMD_ADDR, {ACC_RESP_OKAY, 32'h00001F00});
      $display("test register access done");
      rate_check(1'b0);
      $display("test rates 2.0 done");
      for (int c = 0; c < 8; c++)
         cal_check(c[2:0]);
      $display("test calibration done");
      axi_write(ACC_CMD_ADDR, 32'h00000201, 4'hF, ACC_RESP_OKAY);
      op(0, 1'b0, 1'b0, 1'b0);
      op(1, 1'b0, 1'b0, 1'b0);
      op(2, 1'b1, 1'b0, 1'b0);
      axi_write(ACC_CMD_ADDR, 32'h00000101, 4'hF, ACC_RESP_OKAY);
      op(0, 1'b0, 1'b1, 1'b0);
      op(1, 1'b0, 1'b1, 1'b0);
      op(2, 1'b1, 1'b0, 1'b0);
      axi_write(ACC_CMD_ADDR, 32'h00000301, 4'hF, ACC_RESP_OKAY);
      op(2, 1'b1, 1'b1, 1'b1);
      op(2, 1'b0, 1'b1, 1'b0);
      axi_write(ACC_CMD_ADDR, 32'h00000201, 4'hF, ACC_RESP_OKAY);
      op(2, 1'b1, 1'b1, 1'b1);
      op(2, 1'b1, 1'b0, 1'b0);
      u_acc_agp_master.done_delay = 30;
      axi_write(ACC_CMD_ADDR, 32'h00000101, 4'hF, ACC_RESP_OKAY);
      op(0, 1'b0, 1'b1, 1'b0);
      axi_write(ACC_CMD_ADDR, 32'h00000001, 4'hF, ACC_RESP_OKAY);
      @(posedge aclk);
      check("servicing", servicing, 1'b1);
      for (int n = 0; n < 100 && servicing !== 1'b0; n++)
         @(posedge aclk);
      check("servicing end", servicing, 1'b0);
      u_acc_agp_master.done_delay = 2;
      $display("test operation gating done");
      pg <= 1'b0;
      ref_v3 <= 1'b1;
      repeat (10) @(posedge aclk);
      pg <= 1'b1;
      repeat (10) @(posedge aclk);
      axi_read(ACC_CMD_ADDR, {ACC_RESP_OKAY, 32'h00000A00});
      check("mode", v3, 1'b1);
      axi_write(ACC_CMD_ADDR, 32'h00000101, 4'hF, ACC_RESP_OKAY);
      @(posedge aclk);
      check("sideband", sb_act, 1'b1);
      op(2, 1'b1, 1'b1, 1'b1);
      rate_check(1'b1);
      $display("test signalling 3.0 done");
      // clock enable low: no bus handshake offered, register must survive the freeze
      ce <= 1'b0;
      repeat (2) @(posedge aclk);
      check("frozen readies", {awready, wready, arready}, 3'h0);
      ce <= 1'b1;
      axi_read(ACC_CMD_ADDR, {ACC_RESP_OKAY, 32'h00000001});
      $display("test clock enable done");
      final_report();
   end
endmodule
`default_nettype wire
